// *** hw/usrp_power_ctrl.v ***
// Function
// RQ1: on bus suspend drive suspend indication low and raise suspend/resume interrupt.
// RQ2: software clears the suspend/resume interrupt before continuing the suspend sequence.
// RQ3: software writing PHY sleep request 1 drives PHY low-power output low.
// RQ4: software stops the PHY clock gate after sleep request, restarts it later; here phy_clk_enable_o follows the low-power output.
// RQ5: host resume signalling returns the suspend indication high.
// RQ6: rising suspend indication automatically returns PHY low-power output high.
// RQ7: every suspend indication deassertion raises the suspend/resume interrupt again.
// RQ8: PHY low-power output deasserted lets the PHY clock supply resume.
// RQ9: software waits 2.5 s after wake, then reads bus power sense.
// RQ10: on host resume software follows the resume sequence, not disconnect.
// RQ11: on disconnect software clears PHY sleep request, deasserting PHY low-power output.
// RQ12: clearing wake interrupt and wake enable deasserts the wake output.
// RQ13: setting core soft reset control reinitialises the controller core.
// RQ14: remote wake request in suspend signals wakeup and raises suspend indication.
// RQ15: remote wake request bit self-clears once the PHY clock runs again.
// RQ16: resume while host clock stopped drives wake low and raises wake interrupt.
// RQ17: host clock returning drives PHY low-power high and clears sleep request.
// RQ18: asynchronous bus and PHY events are synchronised before touching interrupt flags.
`timescale 1ns/1ps
`default_nettype none
`include "usrp_defs.vh"

module usrp_power_ctrl #(
    parameter RWAKE_CYC = (`USRP_RWAKE_MS * (`USRP_CLK_HZ / 1000)),
    parameter CORE_RST_CYC = ((`USRP_CORE_RST_NS + `USRP_CLK_PERIOD_NS - 1)
                              / `USRP_CLK_PERIOD_NS)
) (
    input  wire clk_i,
    input  wire rst_n_i,
    // line monitor and PHY, asynchronous
    input  wire bus_suspend_det_i,
    input  wire bus_resume_det_i,
    input  wire bus_supply_present_i,
    input  wire phy_clk_running_i,
    // low-power controller, same domain: high while host clock was gated
    input  wire host_clk_stopped_i,
    // software controls, one-cycle write strobes except the levels susp_irq_en_i and core_soft_reset_ctl_i
    input  wire phy_sleep_set_i,
    input  wire phy_sleep_clr_i,
    input  wire remote_wake_set_i,
    input  wire wake_en_set_i,
    input  wire wake_en_clr_i,
    input  wire susp_irq_clr_i,
    input  wire wake_irq_clr_i,
    input  wire susp_irq_en_i,
    input  wire core_soft_reset_ctl_i,
    // outputs
    output reg  suspend_n_o,
    output reg  phy_low_power_n_o,
    output reg  phy_clk_enable_o,
    output reg  wake_n_o,
    output reg  wake_irq_o,
    output reg  device_ctrl_irq_o,
    output reg  susp_irq_flag_o,
    output reg  phy_sleep_req_o,
    output reg  remote_wake_req_o,
    output reg  remote_wake_sig_o,
    output reg  wake_en_o,
    output reg  bus_power_sense_o,
    output reg  core_reset_n_o
);

    localparam RW_W = 20;
    localparam CR_W = 8;

    // counts are cut to the counter widths on purpose
    localparam integer    RWAKE_M1   = RWAKE_CYC - 1;
    localparam integer    CRST_M1    = CORE_RST_CYC - 1;
    localparam [RW_W-1:0] RWAKE_LAST = RWAKE_M1[RW_W-1:0];
    localparam [CR_W-1:0] CRST_LAST  = CRST_M1[CR_W-1:0];

    // remote wake sequencer
    localparam [1:0] RW_IDLE = 2'b00;
    localparam [1:0] RW_SIG  = 2'b01;
    localparam [1:0] RW_WAIT = 2'b10;

    wire [`USRP_SYNC_W-1:0] sync_w;
    wire                    susp_det_s;
    wire                    resume_det_s;
    wire                    supply_s;
    wire                    phyclk_s;
    wire                    softrst_s;

    reg  suspend_n_r;
    reg  suspend_n_nxt;
    reg  phy_lp_n_r;
    reg  phy_lp_n_nxt;
    reg  sleep_req_r;
    reg  sleep_req_nxt;
    reg  wake_en_r;
    reg  wake_n_r;
    reg  wake_n_nxt;
    reg  wake_flag_r;
    reg  susp_flag_r;
    reg  rwake_req_r;
    reg  rwake_req_nxt;
    reg  susp_det_d_r;
    reg  phyclk_d_r;
    reg  host_stop_d_r;
    reg  softrst_d_r;
    reg  [1:0] rw_state_r;
    reg  [1:0] rw_state_nxt;
    reg  [RW_W-1:0] rw_cnt_r;
    reg  [RW_W-1:0] rw_cnt_nxt;
    reg  [CR_W-1:0] crst_cnt_r;
    reg  crst_busy_r;

    wire suspend_enter_w;
    wire suspend_leave_w;
    wire host_clk_back_w;
    wire phyclk_start_w;
    wire softrst_rise_w;
    wire wake_event_w;

    usrp_sync2 #(
        .W (`USRP_SYNC_W)
    ) u_sync (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .async_i ({core_soft_reset_ctl_i, phy_clk_running_i, bus_supply_present_i,
                   bus_resume_det_i, bus_suspend_det_i}),
        .sync_o  (sync_w)
    ); // RQ18

    assign susp_det_s   = sync_w[`USRP_SI_SUSPEND];
    assign resume_det_s = sync_w[`USRP_SI_RESUME];
    assign supply_s     = sync_w[`USRP_SI_SUPPLY];
    assign phyclk_s     = sync_w[`USRP_SI_PHYCLK];
    assign softrst_s    = sync_w[`USRP_SI_SOFTRST];

    assign suspend_leave_w = !suspend_n_r && suspend_n_nxt;
    assign suspend_enter_w = suspend_n_r && !suspend_n_nxt;
    assign host_clk_back_w = host_stop_d_r && !host_clk_stopped_i;
    assign phyclk_start_w  = phyclk_s && !phyclk_d_r;
    assign softrst_rise_w  = softrst_s && !softrst_d_r;
    // resume seen or supply lost while armed for wake
    assign wake_event_w = wake_en_r && (resume_det_s || !supply_s); // RQ16

    // suspend indication
    always @* begin
        suspend_n_nxt = suspend_n_r;
        if (suspend_n_r) begin
            // a freshly latched suspend is not re-entered while remote wake runs
            if (susp_det_s && !susp_det_d_r && rw_state_r == RW_IDLE) begin
                suspend_n_nxt = 1'b0; // RQ1
            end
        end else if (resume_det_s) begin
            suspend_n_nxt = 1'b1; // RQ5
        end else if (remote_wake_set_i) begin
            suspend_n_nxt = 1'b1; // RQ14
        end
    end

    // phy sleep request and phy low-power output
    always @* begin
        sleep_req_nxt = sleep_req_r;
        phy_lp_n_nxt  = phy_lp_n_r;
        if (phy_sleep_clr_i) begin
            sleep_req_nxt = 1'b0;
            phy_lp_n_nxt  = 1'b1; // RQ11
        end
        if (phy_sleep_set_i) begin
            sleep_req_nxt = 1'b1;
            phy_lp_n_nxt  = 1'b0; // RQ3
        end
        // hardware wake-ups override a same-cycle software set of the low-power output; only host clock return also clears the sleep request
        if (suspend_leave_w) begin
            phy_lp_n_nxt = 1'b1; // RQ6
        end
        if (host_clk_back_w) begin
            phy_lp_n_nxt  = 1'b1; // RQ17
            sleep_req_nxt = 1'b0; // RQ17
        end
    end

    // remote wake signalling sequencer
    always @* begin
        rw_state_nxt  = rw_state_r;
        rw_cnt_nxt    = rw_cnt_r;
        rwake_req_nxt = rwake_req_r;
        case (rw_state_r)
            RW_IDLE: begin
                if (remote_wake_set_i && !suspend_n_r) begin
                    rwake_req_nxt = 1'b1;
                    rw_cnt_nxt    = {RW_W{1'b0}};
                    rw_state_nxt  = RW_SIG; // RQ14
                end
            end
            RW_SIG: begin
                if (rw_cnt_r == RWAKE_LAST) begin
                    rw_state_nxt = RW_WAIT;
                end else begin
                    rw_cnt_nxt = rw_cnt_r + 1'b1;
                end
            end
            RW_WAIT: begin
                // request bit stays until the phy clock is back
                if (!rwake_req_r) begin
                    rw_state_nxt = RW_IDLE;
                end
            end
            default: begin
                rw_state_nxt = RW_IDLE;
            end
        endcase
        if (phyclk_start_w && rwake_req_r) begin
            rwake_req_nxt = 1'b0; // RQ15
        end
    end

    // wake output: released only once flag and enable are both gone
    always @* begin
        wake_n_nxt = wake_n_r;
        if (wake_event_w) begin
            wake_n_nxt = 1'b0; // RQ16
        end else if (!wake_flag_r && !wake_en_r) begin
            wake_n_nxt = 1'b1; // RQ12
        end
    end

    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            suspend_n_r   <= `USRP_SUSPEND_N_RST;
            phy_lp_n_r    <= `USRP_PHY_LP_N_RST;
            sleep_req_r   <= `USRP_SLEEP_REQ_RST;
            wake_en_r     <= `USRP_WAKE_EN_RST;
            wake_n_r      <= `USRP_WAKE_N_RST;
            wake_flag_r   <= `USRP_IRQ_FLAG_RST;
            susp_flag_r   <= `USRP_IRQ_FLAG_RST;
            rwake_req_r   <= `USRP_RWAKE_REQ_RST;
            susp_det_d_r  <= 1'b0;
            phyclk_d_r    <= 1'b0;
            host_stop_d_r <= 1'b0;
            softrst_d_r   <= 1'b0;
            rw_state_r    <= RW_IDLE;
            rw_cnt_r      <= {RW_W{1'b0}};
        end else begin
            suspend_n_r   <= suspend_n_nxt;
            phy_lp_n_r    <= phy_lp_n_nxt;
            sleep_req_r   <= sleep_req_nxt;
            wake_n_r      <= wake_n_nxt;
            rwake_req_r   <= rwake_req_nxt;
            rw_state_r    <= rw_state_nxt;
            rw_cnt_r      <= rw_cnt_nxt;
            susp_det_d_r  <= susp_det_s;
            phyclk_d_r    <= phyclk_s;
            host_stop_d_r <= host_clk_stopped_i;
            softrst_d_r   <= softrst_s;
            if (wake_en_set_i) begin
                wake_en_r <= 1'b1;
            end else if (wake_en_clr_i) begin
                wake_en_r <= 1'b0; // RQ12
            end
            // set wins over a same-cycle clear
            if (suspend_enter_w || suspend_leave_w) begin
                susp_flag_r <= 1'b1; // RQ1 RQ7
            end else if (susp_irq_clr_i) begin
                susp_flag_r <= 1'b0;
            end
            if (wake_event_w) begin
                wake_flag_r <= 1'b1; // RQ16
            end else if (wake_irq_clr_i) begin
                wake_flag_r <= 1'b0; // RQ12
            end
        end
    end

    // core reinit pulse on a rising soft reset control
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            crst_busy_r <= 1'b1;
            crst_cnt_r  <= {CR_W{1'b0}};
        end else if (softrst_rise_w) begin
            crst_busy_r <= 1'b1; // RQ13
            crst_cnt_r  <= {CR_W{1'b0}};
        end else if (crst_busy_r) begin
            if (crst_cnt_r == CRST_LAST) begin
                crst_busy_r <= 1'b0;
            end else begin
                crst_cnt_r <= crst_cnt_r + 1'b1;
            end
        end
    end

    // registered outputs, one cycle behind the state
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            suspend_n_o       <= `USRP_SUSPEND_N_RST;
            phy_low_power_n_o <= `USRP_PHY_LP_N_RST;
            phy_clk_enable_o  <= 1'b0;
            wake_n_o          <= `USRP_WAKE_N_RST;
            wake_irq_o        <= 1'b0;
            device_ctrl_irq_o <= 1'b0;
            susp_irq_flag_o   <= `USRP_IRQ_FLAG_RST;
            phy_sleep_req_o   <= `USRP_SLEEP_REQ_RST;
            remote_wake_req_o <= `USRP_RWAKE_REQ_RST;
            remote_wake_sig_o <= 1'b0;
            wake_en_o         <= `USRP_WAKE_EN_RST;
            bus_power_sense_o <= 1'b0;
            core_reset_n_o    <= `USRP_CORE_RST_N_RST;
        end else begin
            suspend_n_o       <= suspend_n_r;
            phy_low_power_n_o <= phy_lp_n_r;
            // phy clock supply follows the low-power output
            phy_clk_enable_o  <= phy_lp_n_r; // RQ8
            wake_n_o          <= wake_n_r;
            wake_irq_o        <= wake_flag_r;
            device_ctrl_irq_o <= susp_flag_r && susp_irq_en_i;
            susp_irq_flag_o   <= susp_flag_r;
            phy_sleep_req_o   <= sleep_req_r;
            remote_wake_req_o <= rwake_req_r;
            remote_wake_sig_o <= (rw_state_r == RW_SIG); // RQ14
            wake_en_o         <= wake_en_r;
            // software samples this after its settle wait
            bus_power_sense_o <= supply_s; // RQ9
            core_reset_n_o    <= !crst_busy_r; // RQ13
        end
    end

endmodule

`default_nettype wire

// *** hw/usrp_defs.vh ***
`ifndef USRP_DEFS_VH
`define USRP_DEFS_VH

// clock rate of clk_i
`define USRP_CLK_HZ          50000000
`define USRP_CLK_PERIOD_NS   20

// remote wakeup resume signalling length on the bus, in ms
`define USRP_RWAKE_MS        10
// length of the core reinit pulse, in ns
`define USRP_CORE_RST_NS     320

// reset values
`define USRP_SUSPEND_N_RST   1'b1
`define USRP_PHY_LP_N_RST    1'b1
`define USRP_WAKE_N_RST      1'b1
`define USRP_SLEEP_REQ_RST   1'b0
`define USRP_RWAKE_REQ_RST   1'b0
`define USRP_WAKE_EN_RST     1'b0
`define USRP_IRQ_FLAG_RST    1'b0
`define USRP_CORE_RST_N_RST  1'b0

// positions within the synchronised input vector
`define USRP_SYNC_W          5
`define USRP_SI_SUSPEND      0
`define USRP_SI_RESUME       1
`define USRP_SI_SUPPLY       2
`define USRP_SI_PHYCLK       3
`define USRP_SI_SOFTRST      4

`endif

// *** hw/usrp_sync2.v ***
`timescale 1ns/1ps
`default_nettype none

module usrp_sync2 #(
    parameter W = 1
) (
    input  wire         clk_i,
    input  wire         rst_n_i,
    input  wire [W-1:0] async_i,
    output reg  [W-1:0] sync_o
);

    reg [W-1:0] meta_r;

    // first stage feeds only the second stage
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_r <= {W{1'b0}};
            sync_o <= {W{1'b0}};
        end else begin
            meta_r <= async_i;
            sync_o <= meta_r;
        end
    end

endmodule

`default_nettype wire

// *** verif/usrp_power_ctrl_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
module usrp_power_ctrl_checker (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic bus_suspend_det_i,
    input wire logic bus_resume_det_i,
    input wire logic phy_clk_running_i,
    input wire logic host_clk_stopped_i,
    input wire logic phy_sleep_set_i,
    input wire logic remote_wake_set_i,
    input wire logic core_soft_reset_ctl_i,
    input wire logic suspend_n_o,
    input wire logic phy_low_power_n_o,
    input wire logic phy_clk_enable_o,
    input wire logic wake_n_o,
    input wire logic wake_irq_o,
    input wire logic susp_irq_flag_o,
    input wire logic phy_sleep_req_o,
    input wire logic remote_wake_req_o,
    input wire logic remote_wake_sig_o,
    input wire logic wake_en_o,
    input wire logic core_reset_n_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // suspend entry is refused while remote wake is in progress; cycles with resume asserted are skipped by the check
    sequence susp_seen_s;
        $rose(bus_suspend_det_i) && suspend_n_o && !bus_resume_det_i && !remote_wake_sig_o;
    endsequence
    sequence core_pulse_s;
        ##[1:5] !core_reset_n_o ##1 !core_reset_n_o [*8];
    endsequence
    susp_enter_a: assert property (susp_seen_s |-> ##[3:5] !suspend_n_o)
        else $error("suspend not entered");
    susp_flag_a: assert property ($fell(suspend_n_o) |-> susp_irq_flag_o)
        else $error("no irq on suspend");
    resume_exit_a: assert property ($rose(bus_resume_det_i) && !suspend_n_o |=>
        !suspend_n_o ##[1:4] suspend_n_o) else $error("resume exit timing");
    lp_release_a: assert property ($rose(suspend_n_o) |-> phy_low_power_n_o)
        else $error("low power kept after suspend exit");
    resume_irq_a: assert property ($rose(suspend_n_o) |-> susp_irq_flag_o)
        else $error("no irq on suspend exit");
    clk_resume_a: assert property ($rose(phy_low_power_n_o) |=> phy_clk_enable_o)
        else $error("phy clock not resumed");
    sleep_req_a: assert property (phy_sleep_set_i && !host_clk_stopped_i && !bus_resume_det_i
        |-> ##2 phy_sleep_req_o && !phy_low_power_n_o) else $error("sleep request");
    rwake_a: assert property (remote_wake_set_i && !suspend_n_o && !remote_wake_sig_o
        |-> ##2 suspend_n_o && remote_wake_sig_o && remote_wake_req_o) else $error("rwake");
    rwake_clr_a: assert property ($rose(phy_clk_running_i) && remote_wake_req_o
        |-> ##[2:6] !remote_wake_req_o) else $error("remote wake bit not cleared");
    wake_irq_a: assert property ($fell(wake_n_o) |-> wake_irq_o)
        else $error("wake without irq");
    wake_rel_a: assert property (!wake_irq_o && !wake_en_o |-> ##[0:2] wake_n_o)
        else $error("wake output stuck");
    hclk_back_a: assert property ($fell(host_clk_stopped_i) |->
        ##2 phy_low_power_n_o && !phy_sleep_req_o) else $error("host clock return");
    core_init_a: assert property ($rose(core_soft_reset_ctl_i) |-> core_pulse_s)
        else $error("core reset pulse");
endmodule
bind usrp_power_ctrl usrp_power_ctrl_checker u_chk (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .bus_suspend_det_i(bus_suspend_det_i), .bus_resume_det_i(bus_resume_det_i),
    .phy_clk_running_i(phy_clk_running_i), .host_clk_stopped_i(host_clk_stopped_i),
    .phy_sleep_set_i(phy_sleep_set_i), .remote_wake_set_i(remote_wake_set_i),
    .core_soft_reset_ctl_i(core_soft_reset_ctl_i), .suspend_n_o(suspend_n_o),
    .phy_low_power_n_o(phy_low_power_n_o), .phy_clk_enable_o(phy_clk_enable_o),
    .wake_n_o(wake_n_o), .wake_irq_o(wake_irq_o), .susp_irq_flag_o(susp_irq_flag_o),
    .phy_sleep_req_o(phy_sleep_req_o), .remote_wake_req_o(remote_wake_req_o),
    .remote_wake_sig_o(remote_wake_sig_o), .wake_en_o(wake_en_o),
    .core_reset_n_o(core_reset_n_o));
`default_nettype wire

// *** verif/usrp_phy_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module usrp_phy_model (
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       clk_en_i,
    input  wire logic [3:0] lag_i,
    output var  logic       running_o
);
    logic [3:0] cnt_r;
    // oscillator restart takes lag_i + 1 cycles, so slow phys are covered too
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i || !clk_en_i) begin
            cnt_r <= 4'h0;
            running_o <= 1'h0;
        end else if (cnt_r == lag_i) begin
            running_o <= 1'h1;
        end else begin
            cnt_r <= cnt_r + 4'h1;
        end
    end
endmodule
`default_nettype wire

// *** verif/usrp_power_ctrl_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module usrp_power_ctrl_test;
    logic clk_i = 1'h0, rst_n_i = 1'h0, bus_suspend_det_i = 1'h0, bus_resume_det_i = 1'h0;
    logic bus_supply_present_i = 1'h1, host_clk_stopped_i = 1'h0, phy_clk_running_i;
    logic phy_sleep_set_i, phy_sleep_clr_i, remote_wake_set_i, wake_en_set_i, wake_en_clr_i;
    logic susp_irq_clr_i, wake_irq_clr_i, susp_irq_en_i, core_soft_reset_ctl_i;
    logic suspend_n_o, phy_low_power_n_o, phy_clk_enable_o, wake_n_o, wake_irq_o;
    logic device_ctrl_irq_o, susp_irq_flag_o, phy_sleep_req_o, remote_wake_req_o;
    logic remote_wake_sig_o, wake_en_o, bus_power_sense_o, core_reset_n_o;
    logic [8:0] sw = 9'h000;
    logic [3:0] lag = 4'h0;
    int failures = 0, total_checks = 0, cyc = 0;
    // bits: 0 sleep set, 1 sleep clr, 2 rwake, 3/4 wake en set/clr, 5/6 irq clr, 7 en, 8 core
    assign {core_soft_reset_ctl_i, susp_irq_en_i, wake_irq_clr_i, susp_irq_clr_i, wake_en_clr_i,
            wake_en_set_i, remote_wake_set_i, phy_sleep_clr_i, phy_sleep_set_i} = sw;
    usrp_power_ctrl #(.RWAKE_CYC(8)) u_usrp_power_ctrl (
        .clk_i                (clk_i),                .rst_n_i              (rst_n_i),
        .bus_suspend_det_i    (bus_suspend_det_i),    .bus_resume_det_i     (bus_resume_det_i),
        .bus_supply_present_i (bus_supply_present_i), .phy_clk_running_i    (phy_clk_running_i),
        .host_clk_stopped_i   (host_clk_stopped_i),   .phy_sleep_set_i      (phy_sleep_set_i),
        .phy_sleep_clr_i      (phy_sleep_clr_i),      .remote_wake_set_i    (remote_wake_set_i),
        .wake_en_set_i        (wake_en_set_i),        .wake_en_clr_i        (wake_en_clr_i),
        .susp_irq_clr_i       (susp_irq_clr_i),       .wake_irq_clr_i       (wake_irq_clr_i),
        .susp_irq_en_i        (susp_irq_en_i),
        .core_soft_reset_ctl_i(core_soft_reset_ctl_i),
        .suspend_n_o          (suspend_n_o),          .phy_low_power_n_o    (phy_low_power_n_o),
        .phy_clk_enable_o     (phy_clk_enable_o),     .wake_n_o             (wake_n_o),
        .wake_irq_o           (wake_irq_o),           .device_ctrl_irq_o    (device_ctrl_irq_o),
        .susp_irq_flag_o      (susp_irq_flag_o),      .phy_sleep_req_o      (phy_sleep_req_o),
        .remote_wake_req_o    (remote_wake_req_o),    .remote_wake_sig_o    (remote_wake_sig_o),
        .wake_en_o            (wake_en_o),            .bus_power_sense_o    (bus_power_sense_o),
        .core_reset_n_o       (core_reset_n_o));
    usrp_phy_model u_usrp_phy_model (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .clk_en_i(phy_clk_enable_o), .lag_i(lag), .running_o(phy_clk_running_i));
    always #10 clk_i = ~clk_i;
    task end_sim;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            failures++;
            end_sim;
        end
    end
    task chk(input logic g, input logic e);
        total_checks++;
        if (g !== e) begin
            failures++;
            $display("[ERR] %0t got %b expected %b", $time, g, e);
        end
    endtask
    task automatic wt(ref logic s, input logic v);
        int k = 0;
        while (s !== v && k < 40) begin
            @(posedge clk_i);
            #1;
            k++;
        end
        chk(s, v);
    endtask
    task pulse(input int b);
        @(posedge clk_i);
        sw[b] <= 1'h1;
        @(posedge clk_i);
        sw[b] <= 1'h0;
        #1;
    endtask
    initial begin
        void'($urandom(13));
        repeat (8) @(posedge clk_i);
        chk(core_reset_n_o, 1'h0);
        rst_n_i <= 1'h1;
        repeat (18) @(posedge clk_i);
        #1;
        chk(core_reset_n_o, 1'h1);
        for (int i = 0; i < 8; i++) begin
            lag <= 4'($urandom % 8);
            sw[7] <= 1'($urandom);
            bus_suspend_det_i <= 1'h1;
            wt(suspend_n_o, 1'h0);
            chk(susp_irq_flag_o, 1'h1);
            chk(device_ctrl_irq_o, sw[7]);
            pulse(5);
            wt(susp_irq_flag_o, 1'h0);
            pulse(0);
            wt(phy_low_power_n_o, 1'h0);
            chk(phy_sleep_req_o, 1'h1);
            wt(phy_clk_running_i, 1'h0);
            if (i < 2 || $urandom % 2) begin
                bus_suspend_det_i <= 1'h0;
                bus_resume_det_i <= 1'h1;
                wt(suspend_n_o, 1'h1);
                chk(phy_low_power_n_o, 1'h1);
                chk(susp_irq_flag_o, 1'h1);
                bus_resume_det_i <= 1'h0;
            end else begin
                pulse(2);
                repeat (2) @(posedge clk_i);
                #1;
                chk(suspend_n_o, 1'h1);
                chk(remote_wake_sig_o, 1'h1);
                chk(remote_wake_req_o, 1'h1);
                bus_suspend_det_i <= 1'h0;
                wt(remote_wake_req_o, 1'h0);
            end
            wt(phy_clk_running_i, 1'h1);
            pulse(5);
            pulse(1);
            repeat (12) @(posedge clk_i);
        end
        pulse(3);
        bus_supply_present_i <= 1'h0;
        wt(wake_n_o, 1'h0);
        chk(wake_irq_o, 1'h1);
        chk(bus_power_sense_o, 1'h0);
        bus_supply_present_i <= 1'h1;
        // let the restored supply through the synchroniser, else the clear loses to the set
        repeat (3) @(posedge clk_i);
        #1;
        chk(bus_power_sense_o, 1'h1);
        pulse(6);
        repeat (5) @(posedge clk_i);
        #1;
        chk(wake_irq_o, 1'h0);
        chk(wake_n_o, 1'h0);
        pulse(4);
        wt(wake_n_o, 1'h1);
        host_clk_stopped_i <= 1'h1;
        pulse(0);
        wt(phy_low_power_n_o, 1'h0);
        host_clk_stopped_i <= 1'h0;
        repeat (3) @(posedge clk_i);
        #1;
        chk(phy_low_power_n_o, 1'h1);
        chk(phy_sleep_req_o, 1'h0);
        pulse(0);
        wt(phy_low_power_n_o, 1'h0);
        pulse(1);
        wt(phy_low_power_n_o, 1'h1);
        sw[8] <= 1'h1;
        wt(core_reset_n_o, 1'h0);
        wt(core_reset_n_o, 1'h1);
        end_sim;
    end
endmodule
`default_nettype wire
